// ### rtl/adc_port_defs.svh
// Purpose: Constants of the two-wire result port (offsets, fields, resets)
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

// ****************************************************************
// Frame shape
// ****************************************************************
`define BITS_PER_BYTE   4'h8
`define RESULT_BYTES    3'h4
`define SETUP_RST       16'h0000
`define RESULT_RST      32'h00000000
`define CNT_RST         4'h0

// ****************************************************************
// Setup word fields (first byte high, second byte low)
// ****************************************************************
`define CH_ENABLE_CODE  3'h5
`define CFG_EN2_BIT     7
`define CFG_TEMP_BIT    6
`define CFG_SPEED_BIT   3

// ****************************************************************
// Result word codes
// ****************************************************************
`define OVER_CODE       32'hc0000000
`define UNDER_HI_1X     26'h0ffffff
`define UNDER_HI_2X     20'h3ffff

`endif

// ### rtl/adc_port_pkg.sv
// Purpose: Types of the two-wire result port
// Assumes: Nothing
// Notes:   Constants live in adc_port_defs.svh
package adc_port_pkg;

  // Serial link states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_WR_BYTE  = 7'b0001000,
    ST_WR_ACK   = 7'b0010000,
    ST_RD_BYTE  = 7'b0100000,
    ST_RD_ACK   = 7'b1000000
  } link_state_t;

endpackage : adc_port_pkg

// ### rtl/result_word_former.sv
// Purpose: Builds and holds the 32-bit conversion result word
// Assumes: load_i pulses once per finished conversion
// Notes:   Word only changes on load_i, so a read sees one conversion
`include "adc_port_defs.svh"

module result_word_former (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        load_i,
  input  wire logic        double_i,
  input  wire logic        pos_i,
  input  wire logic        over_i,
  input  wire logic        under_i,
  input  wire logic [23:0] value_i,
  input  wire logic [5:0]  sub_i,
  output logic      [31:0] word_o
);

  logic [31:0] word_d;
  logic        zero;
  logic        pol;

  // ****************************************************************
  // Encoding
  // ****************************************************************
  // Zero code takes the core's polarity only in double speed, where
  // the core's offset is uncalibrated and the sign may dither
  always_comb begin
    word_d = word_o;
    zero   = (value_i == 24'h000000);
    pol    = zero ? (pos_i | ~double_i) : ~value_i[23];     // R15 R19
    if (load_i) begin
      if (over_i) begin
        word_d = `OVER_CODE;                                // R16 R18
      end else if (under_i && double_i) begin
        word_d = {`UNDER_HI_2X, value_i[5:0], sub_i};       // R20
      end else if (under_i) begin
        word_d = {`UNDER_HI_1X, sub_i};                     // R16 R18
      end else begin
        word_d = {pol, ~zero & value_i[23], value_i, sub_i}; // R17
      end
    end
  end

  // Result register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      word_o <= `RESULT_RST;
    end else begin
      word_o <= word_d;                                     // R10
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_OVER_CODE: assert property (load_i && over_i |=> // R18
    word_o == 32'hc0000000) else $error("over code wrong");
  AST_UNDER_CODE: assert property (load_i && under_i && !over_i // R16
    |=> word_o[31:30] == 2'b00 && word_o[29:12] == 18'h3ffff)
    else $error("under code wrong");
  AST_HOLD: assert property (!load_i |=> $stable(word_o)) // R25
    else $error("result changed without load");
  COV_UNDER_2X: cover property (load_i && under_i && double_i);

endmodule : result_word_former

// ### rtl/adc_twowire_result_port.sv
// Purpose: Two-wire target port of a converter: address, setup, result
// Assumes: SCL_I/SDA_I synchronous to CLK_I; SCL low/high >= 2 clocks
// Notes:   Summary of operation is listed below
//
// Summary of operation
// R1 - Controller frames transfers with START and STOP
// R2 - Repeated START keeps bus busy, no conversion
// R3 - Each unit: eight data bits plus acknowledge
// R4 - Ninth clock: receiver pulls low to acknowledge
// R5 - Data changes only while clock low
// R6 - Controller sends 7-bit address then direction
// R7 - Answer only own pin-selected address
// R8 - Not acknowledge while conversion runs
// R9 - Acknowledge matching address when conversion finished
// R10 - Hold 32-bit result and 16-bit setup
// R11 - Sleep after conversion until addressed
// R12 - Read acknowledges, then up to four bytes
// R13 - Full read starts conversion, later reads refused
// R14 - Result shifted MSB first on falling clock
// R15 - First bit is result polarity
// R16 - Bits 31 and 30 encode range
// R17 - 24-bit two's complement plus six sub bits
// R18 - Out of range inputs clamp to codes
// R19 - Double speed zero code polarity may toggle
// R20 - Double speed underrange pattern fixed
// R21 - Target only; data line pulled low or released
// R22 - Works at 100 and 400 kbit/s
// R23 - Sample incoming bits on rising clock
// R24 - STOP after write or short read converts
// R25 - Result unchanged during a read
`include "adc_port_defs.svh"

module adc_twowire_result_port #(
  // Nine selectable addresses, entry i at [7*i +: 7]; values arbitrary
  parameter logic [62:0] ADDR_TABLE = {7'h18, 7'h17, 7'h16, 7'h15,
                                       7'h14, 7'h13, 7'h12, 7'h11,
                                       7'h10}
) (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_N_O,
  input  wire logic [3:0]  ADDR_PIN_I,
  output logic             CONV_START_O,
  input  wire logic        CONV_DONE_I,
  input  wire logic [23:0] CONV_VALUE_I,
  input  wire logic [5:0]  CONV_SUB_I,
  input  wire logic        CONV_POS_I,
  input  wire logic        CONV_OVER_I,
  input  wire logic        CONV_UNDER_I,
  output logic [15:0]      SETUP_O,
  output logic             SLEEP_O
);

  adc_port_pkg::link_state_t st_q, st_d;
  logic        scl_q, sda_q;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d;
  logic [31:0] tx_q, tx_d;
  logic        oe_n_q, oe_n_d;
  logic        dir_q, dir_d;
  logic [2:0]  nbytes_q, nbytes_d;
  logic        mack_q, mack_d;
  logic        pend_q, pend_d;
  logic        busy_q, busy_d;
  logic        start_q, start_d;
  logic        en_q, en_d;
  logic [15:0] setup_q, setup_d;
  logic        sleep_q, sleep_d;
  logic [6:0]  own_addr_q;
  logic [31:0] result;
  logic        scl_rise, scl_fall, bus_start, bus_stop;

  // ****************************************************************
  // Address select
  // ****************************************************************
  // Each pin is three-state: 0 low, 1 high, 2 or 3 floating
  function automatic logic [6:0] addr_lookup(input logic [3:0] pins);
    logic [1:0] p0;
    logic [1:0] p1;
    logic [3:0] idx;
    p0  = (pins[1:0] == 2'h3) ? 2'h2 : pins[1:0];
    p1  = (pins[3:2] == 2'h3) ? 2'h2 : pins[3:2];
    idx = 4'({p1, 1'b0}) + 4'(p1) + 4'(p0);
    return ADDR_TABLE[7 * idx +: 7];
  endfunction : addr_lookup

  // ****************************************************************
  // Line edges
  // ****************************************************************
  // Previous line levels; idle bus reads high
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      own_addr_q <= 7'h00;
    end else begin
      scl_q      <= SCL_I;
      sda_q      <= SDA_I;
      own_addr_q <= addr_lookup(ADDR_PIN_I);               // R7
    end
  end

  assign scl_rise  = SCL_I & ~scl_q;                       // R22 R23
  assign scl_fall  = ~SCL_I & scl_q;
  // SDA moving while SCL stays high marks a frame edge
  assign bus_start = scl_q & SCL_I & sda_q & ~SDA_I;       // R1 R5
  assign bus_stop  = scl_q & SCL_I & ~sda_q & SDA_I;       // R1 R5

  // ****************************************************************
  // Result word
  // ****************************************************************
  // Loads only at the end of a conversion, which cannot overlap a read
  result_word_former u_former (
    .clk_i    (CLK_I),
    .nrst_i   (NRST_I),
    .load_i   (CONV_DONE_I & busy_q),                      // R25
    .double_i (setup_q[`CFG_SPEED_BIT] & ~setup_q[`CFG_TEMP_BIT]),
    .pos_i    (CONV_POS_I),
    .over_i   (CONV_OVER_I),
    .under_i  (CONV_UNDER_I),
    .value_i  (CONV_VALUE_I),
    .sub_i    (CONV_SUB_I),
    .word_o   (result)
  );

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  // All SDA changes happen on a falling SCL so the controller never
  // sees a false START or STOP from this end
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    tx_d     = tx_q;
    oe_n_d   = oe_n_q;
    dir_d    = dir_q;
    nbytes_d = nbytes_q;
    mack_d   = mack_q;
    pend_d   = pend_q;
    busy_d   = busy_q;
    start_d  = 1'b0;
    en_d     = en_q;
    setup_d  = setup_q;
    if (CONV_DONE_I) begin
      busy_d = 1'b0;
    end
    if (bus_start) begin
      // Repeated START leaves a pending conversion untouched
      st_d   = adc_port_pkg::ST_ADDR;                      // R2
      cnt_d  = `CNT_RST;
      oe_n_d = 1'b1;
    end else if (bus_stop) begin
      st_d   = adc_port_pkg::ST_IDLE;
      oe_n_d = 1'b1;
      if (pend_q) begin
        start_d = 1'b1;                                    // R24
        busy_d  = 1'b1;
        pend_d  = 1'b0;
      end
    end else begin
      case (st_q)
        adc_port_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], SDA_I};                    // R6 R23
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `BITS_PER_BYTE) begin
            if (sh_q[7:1] == own_addr_q && !busy_q) begin
              oe_n_d = 1'b0;                               // R9
              dir_d  = sh_q[0];
              st_d   = adc_port_pkg::ST_ADDR_ACK;
            end else begin
              st_d = adc_port_pkg::ST_IDLE;                // R7 R8
            end
          end
        end
        adc_port_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_d    = `CNT_RST;
            nbytes_d = 3'h0;
            pend_d   = 1'b1;
            if (dir_q) begin
              oe_n_d = result[31];                         // R14 R15
              tx_d   = {result[30:0], 1'b0};
              st_d   = adc_port_pkg::ST_RD_BYTE;           // R12
            end else begin
              oe_n_d = 1'b1;
              st_d   = adc_port_pkg::ST_WR_BYTE;
            end
          end
        end
        adc_port_pkg::ST_WR_BYTE: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], SDA_I};                    // R23
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `BITS_PER_BYTE) begin
            // Channel byte needs 101; config byte needs EN2 too
            if (nbytes_q == 3'h0) begin
              en_d = (sh_q[7:5] == `CH_ENABLE_CODE);
              if (sh_q[7:5] == `CH_ENABLE_CODE) begin
                setup_d[15:8] = sh_q;                      // R10
              end
            end else if (nbytes_q == 3'h1 && en_q &&
                         sh_q[`CFG_EN2_BIT]) begin
              setup_d[7:0] = sh_q;                         // R10
            end
            if (nbytes_q != 3'h7) begin
              nbytes_d = nbytes_q + 3'h1;
            end
            oe_n_d = 1'b0;                                 // R3 R4
            st_d   = adc_port_pkg::ST_WR_ACK;
          end
        end
        adc_port_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            oe_n_d = 1'b1;
            cnt_d  = `CNT_RST;
            st_d   = adc_port_pkg::ST_WR_BYTE;
          end
        end
        adc_port_pkg::ST_RD_BYTE: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `BITS_PER_BYTE) begin
            oe_n_d   = 1'b1;                               // R3 R4
            nbytes_d = nbytes_q + 3'h1;
            st_d     = adc_port_pkg::ST_RD_ACK;
          end else if (scl_fall && cnt_q != `CNT_RST) begin
            oe_n_d = tx_q[31];                             // R14
            tx_d   = {tx_q[30:0], 1'b0};
          end
        end
        adc_port_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            mack_d = ~SDA_I;                               // R4
          end else if (scl_fall) begin
            cnt_d = `CNT_RST;
            if (nbytes_q == `RESULT_BYTES) begin
              // Whole word out: convert now, refuse until done
              start_d = 1'b1;                              // R13
              busy_d  = 1'b1;
              pend_d  = 1'b0;
              st_d    = adc_port_pkg::ST_IDLE;
            end else if (mack_q) begin
              oe_n_d = tx_q[31];                           // R14
              tx_d   = {tx_q[30:0], 1'b0};
              st_d   = adc_port_pkg::ST_RD_BYTE;
            end else begin
              st_d = adc_port_pkg::ST_IDLE;                // R24
            end
          end
        end
        adc_port_pkg::ST_IDLE: begin
          oe_n_d = 1'b1;
        end
        default: begin
          st_d   = adc_port_pkg::ST_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
    // Asleep once idle after a conversion until addressed again
    sleep_d = ~busy_d & (st_d == adc_port_pkg::ST_IDLE ||
                         st_d == adc_port_pkg::ST_ADDR);   // R11
  end

  // Registers; conversion after reset runs by the core itself
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      st_q     <= adc_port_pkg::ST_IDLE;
      cnt_q    <= `CNT_RST;
      sh_q     <= 8'h00;
      tx_q     <= `RESULT_RST;
      oe_n_q   <= 1'b1;
      dir_q    <= 1'b0;
      nbytes_q <= 3'h0;
      mack_q   <= 1'b0;
      pend_q   <= 1'b0;
      busy_q   <= 1'b1;
      start_q  <= 1'b0;
      en_q     <= 1'b0;
      setup_q  <= `SETUP_RST;
      sleep_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      tx_q     <= tx_d;
      oe_n_q   <= oe_n_d;
      dir_q    <= dir_d;
      nbytes_q <= nbytes_d;
      mack_q   <= mack_d;
      pend_q   <= pend_d;
      busy_q   <= busy_d;
      start_q  <= start_d;
      en_q     <= en_d;
      setup_q  <= setup_d;
      sleep_q  <= sleep_d;
    end
  end

  // Open drain: the driven level is always low
  always_ff @(posedge CLK_I) begin
    SDA_O <= 1'b0;                                         // R21
  end

  assign SDA_OE_N_O   = oe_n_q;
  assign CONV_START_O = start_q;
  assign SETUP_O      = setup_q;
  assign SLEEP_O      = sleep_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  AST_NACK_BUSY: assert property (st_q == adc_port_pkg::ST_ADDR && // R8
    scl_fall && cnt_q == 4'h8 && busy_q && !bus_start && !bus_stop
    |=> SDA_OE_N_O && st_q == adc_port_pkg::ST_IDLE)
    else $error("addressed while busy but acknowledged");
  AST_ACK_MATCH: assert property (st_q == adc_port_pkg::ST_ADDR && // R9
    scl_fall && cnt_q == 4'h8 && !busy_q && sh_q[7:1] == own_addr_q
    |=> !SDA_OE_N_O [*1] ##0 st_q == adc_port_pkg::ST_ADDR_ACK)
    else $error("matching address not acknowledged");
  AST_LOW_ONLY: assert property (##1 SDA_O == 1'b0) // R21
    else $error("data line driven high");
  AST_EDGE_SAFE: assert property ($changed(SDA_OE_N_O) |-> // R5
    $past(scl_fall) || $past(bus_start) || $past(bus_stop))
    else $error("data line moved outside falling clock");
  AST_FULL_READ: assert property (st_q == adc_port_pkg::ST_RD_ACK && // R13
    scl_fall && nbytes_q == 3'h4 && !bus_start && !bus_stop
    |=> CONV_START_O ##1 !CONV_START_O)
    else $error("full read did not start one conversion");
  AST_STOP_CONV: assert property (bus_stop && pend_q // R24
    |=> CONV_START_O && busy_q) else $error("stop did not convert");
  AST_FIRST_BIT: assert property (st_q == adc_port_pkg::ST_ADDR_ACK && // R15
    scl_fall && dir_q && !bus_start && !bus_stop
    |=> SDA_OE_N_O == $past(result[31]))
    else $error("first bit is not polarity");
  AST_NINE: assert property (cnt_q <= 4'h9) // R3
    else $error("unit longer than nine clocks");
  AST_SLEEP: assert property (busy_q && CONV_DONE_I && !pend_q && // R11
    st_q == adc_port_pkg::ST_IDLE |=> SLEEP_O && !busy_q)
    else $error("no sleep after finished conversion");
  AST_REP_START: assert property (bus_start && pend_q |=> // R2
    pend_q && !CONV_START_O) else $error("repeated start converted");

  COV_FULL_READ: cover property (st_q == adc_port_pkg::ST_RD_ACK &&
    nbytes_q == 3'h4 && scl_fall);
  COV_WRITE_ACK: cover property (st_q == adc_port_pkg::ST_WR_ACK);
  COV_NACK_BUSY: cover property (st_q == adc_port_pkg::ST_ADDR &&
    scl_fall && cnt_q == 4'h8 && busy_q);

endmodule : adc_twowire_result_port

// ### bench/twowire_ctl_model.sv
// Purpose: Two-wire bus controller model, clocks SCL and pulls SDA
// Assumes: SDA is resolved outside from both open-drain pulls
// Notes:   One bit takes four quarter spans; drives move 1 ns after clk
module twowire_ctl_model #(
  parameter int QTR = 13
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Bus timing
  // ****************************************************************
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Step off the edge so a drive never races the sampling clock
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  // START and repeated START alike: data falls while clock is high
  task automatic go_start();
    sda_pull_o = 1'b0;
    wt(QTR);
    scl_o = 1'b1;
    wt(QTR);
    sda_pull_o = 1'b1;
    wt(QTR);
    scl_o = 1'b0;
    wt(QTR);
  endtask : go_start

  // STOP: data rises while clock is high
  task automatic go_stop();
    sda_pull_o = 1'b1;
    wt(QTR);
    scl_o = 1'b1;
    wt(QTR);
    sda_pull_o = 1'b0;
    wt(QTR);
  endtask : go_stop

  // One clock pulse, 52 clocks long, so about 385 kbit/s
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o = ~b;
    wt(QTR);
    scl_o = 1'b1;
    wt(QTR);
    r = sda_i;
    wt(QTR);
    scl_o = 1'b0;
    wt(QTR);
  endtask : bit_io

  // ****************************************************************
  // Byte units
  // ****************************************************************
  // Eight bits MSB first, then released for the answer
  task automatic put_byte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, nack);
  endtask : put_byte

  // Released for eight bits, then acknowledge unless last
  task automatic get_byte(output logic [7:0] b, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : get_byte
endmodule : twowire_ctl_model

// ### bench/adc_twowire_result_port_test.sv
// Purpose: Self-checking bench of the two-wire result port
// Assumes: Conversion core is played by the bench through serve
// Notes:   Each scenario starts with a conversion pending in the device
module adc_twowire_result_port_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk   = 1'b0;
  logic        nrst  = 1'b0;
  logic [3:0]  pins  = 4'h0;
  logic        done  = 1'b0;
  logic        over  = 1'b0;
  logic        under = 1'b0;
  logic        pos   = 1'b0;
  logic [23:0] value = 24'h000000;
  logic [5:0]  sub   = 6'h00;
  logic [6:0]  own   = 7'h10;
  logic        scl, ctl_pull, sda_o, sda_oe_n, conv_start, sleep_o;
  logic [15:0] setup_o;
  wire         sda_line;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          starts    = 0;

  // Open drain: line is high unless either party pulls it
  assign sda_line = ~(ctl_pull | ~sda_oe_n);

  always #25 clk = ~clk;

  adc_twowire_result_port dut_u (
    .CLK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda_line),
    .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .ADDR_PIN_I(pins),
    .CONV_START_O(conv_start), .CONV_DONE_I(done),
    .CONV_VALUE_I(value), .CONV_SUB_I(sub), .CONV_POS_I(pos),
    .CONV_OVER_I(over), .CONV_UNDER_I(under), .SETUP_O(setup_o),
    .SLEEP_O(sleep_o)
  );

  twowire_ctl_model ctl_u (
    .clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(ctl_pull)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Count start pulses; each stands one clock
  always @(posedge clk) if (conv_start === 1'b1) starts++;

  // Data pin level must never be anything but low
  always @(posedge clk) if (nrst) cmp1(sda_o, 1'b0);

  task automatic cmp1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Finish the pending conversion with the given core outputs
  task automatic serve(input logic ov, un, ps, input logic [23:0] v,
                       input logic [5:0] s);
    tick(5);
    {over, under, pos} = {ov, un, ps};
    value = v;
    sub = s;
    done = 1'b1;
    tick(1);
    done = 1'b0;
    tick(2);
  endtask : serve

  // Read n bytes; the START doubles as repeated START when bus is busy
  task automatic rd(input int n, output logic [31:0] w, output logic na);
    logic [7:0] b;
    w = 32'h0;
    ctl_u.go_start();
    ctl_u.put_byte({own, 1'b1}, na);
    for (int i = 0; i < n && na === 1'b0; i++) begin
      ctl_u.get_byte(b, i == n - 1);
      w = {w[23:0], b};
    end
    ctl_u.go_stop();
  endtask : rd

  task automatic wr(input int n, input logic [7:0] b0, b1,
                    output logic na);
    logic x;
    ctl_u.go_start();
    ctl_u.put_byte({own, 1'b0}, na);
    if (n > 0) ctl_u.put_byte(b0, x);
    if (n > 0) cmp1(x, 1'b0);
    if (n > 1) ctl_u.put_byte(b1, x);
    if (n > 1) cmp1(x, 1'b0);
    ctl_u.go_stop();
  endtask : wr

  // One conversion read in full, then a refused read while busy
  task automatic enc_case(input logic ov, un, ps, input logic [23:0] v,
                          input logic [5:0] s, input logic [31:0] exp);
    logic [31:0] w;
    logic        a;
    int          k;
    serve(ov, un, ps, v, s);
    cmp1(sleep_o, 1'b1);
    k = starts;
    rd(4, w, a);
    cmp1(a, 1'b0);
    cmp32(w, exp);
    cmp32(32'(starts - k), 32'h1);
    cmp1(sleep_o, 1'b0);
    rd(1, w, a);
    cmp1(a, 1'b1);
  endtask : enc_case

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_power();
    logic [31:0] w;
    logic        a;
    cmp32(32'(setup_o), 32'h0);
    cmp1(sda_oe_n, 1'b1);
    rd(1, w, a);
    cmp1(a, 1'b1);
    cmp32(32'(starts), 32'h0);
  endtask : t_power

  task automatic t_enc1x();
    enc_case(0, 0, 1, 24'h123456, 6'h2a, {2'b10, 24'h123456, 6'h2a});
    enc_case(0, 0, 0, 24'hfedcba, 6'h15, {2'b01, 24'hfedcba, 6'h15});
    enc_case(0, 0, 0, 24'h000000, 6'h01, {2'b10, 24'h0, 6'h01});
    enc_case(1, 0, 1, 24'h7fffff, 6'h3f, 32'hc0000000);
    enc_case(0, 1, 0, 24'h800000, 6'h0a, {2'b00, 24'hffffff, 6'h0a});
  endtask : t_enc1x

  // Every strap setting selects its own address and refuses the next one
  task automatic t_addr();
    logic [31:0] w;
    logic        a;
    int          k;
    for (int i = 0; i < 9; i++) begin
      serve(0, 0, 1, 24'h000001, 6'h00);
      pins = {2'(i / 3), 2'(i % 3)};
      own = 7'h10 + 7'((i + 1) % 9);
      rd(1, w, a);
      cmp1(a, 1'b1);
      own = 7'h10 + 7'(i);
      k = starts;
      wr(0, 8'h00, 8'h00, a);
      cmp1(a, 1'b0);
      cmp32(32'(starts - k), 32'h1);
    end
  endtask : t_addr

  // Setup bytes land only under the enable patterns
  task automatic t_setup();
    logic a;
    serve(0, 0, 1, 24'h000002, 6'h00);
    wr(2, 8'ha5, 8'h8a, a);
    cmp32(32'(setup_o), 32'h0000a58a);
    serve(0, 0, 1, 24'h000002, 6'h00);
    wr(2, 8'h85, 8'hff, a);
    cmp32(32'(setup_o), 32'h0000a58a);
    serve(0, 0, 1, 24'h000002, 6'h00);
    wr(2, 8'hb3, 8'h08, a);
    cmp32(32'(setup_o), 32'h0000b38a);
    serve(0, 0, 1, 24'h000002, 6'h00);
    wr(2, 8'ha5, 8'h88, a);
    cmp32(32'(setup_o), 32'h0000a588);
  endtask : t_setup

  // Temperature select forces single speed even with the speed bit set
  task automatic t_enc2x();
    logic a;
    enc_case(0, 1, 0, 24'h80002d, 6'h11,
             {2'b00, 18'h3ffff, 6'h2d, 6'h11});
    enc_case(0, 0, 0, 24'h000000, 6'h00, 32'h00000000);
    enc_case(0, 0, 1, 24'h000000, 6'h00, 32'h80000000);
    serve(0, 0, 1, 24'h000002, 6'h00);
    wr(2, 8'ha5, 8'hc8, a);
    cmp32(32'(setup_o), 32'h0000a5c8);
    enc_case(0, 0, 0, 24'h000000, 6'h00, 32'h80000000);
  endtask : t_enc2x

  // Read cut short by the controller converts on STOP
  task automatic t_short();
    logic [31:0] w;
    logic        a;
    int          k;
    serve(0, 0, 1, 24'h00ff00, 6'h00);
    k = starts;
    rd(1, w, a);
    cmp32(w, 32'h00000080);
    cmp32(32'(starts - k), 32'h1);
  endtask : t_short

  // Write, repeated START, full read: one conversion only
  task automatic t_restart();
    logic [31:0] w;
    logic        a;
    int          k;
    serve(0, 0, 1, 24'h000001, 6'h3f);
    k = starts;
    ctl_u.go_start();
    ctl_u.put_byte({own, 1'b0}, a);
    cmp1(a, 1'b0);
    rd(4, w, a);
    cmp32(w, {2'b10, 24'h000001, 6'h3f});
    cmp32(32'(starts - k), 32'h1);
  endtask : t_restart

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Watchdog well above the roughly 50000 clocks of the sequence
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    tick(20);
    nrst = 1'b1;
    tick(2);
    t_power();
    t_enc1x();
    t_addr();
    t_setup();
    t_enc2x();
    t_short();
    t_restart();
    test_done();
  end
endmodule : adc_twowire_result_port_test
